/* File: logic/psic_map.svh */
`ifndef PSIC_MAP_SVH
`define PSIC_MAP_SVH

// Register numbers on the management port
`define PSIC_REG_INT 5'h1B
`define PSIC_REG_CABLE 5'h1D
`define PSIC_REG_PHYSTAT 5'h1E
`define PSIC_REG_CTRL2 5'h1F

// Interrupt control/status fields
`define PSIC_INT_EN_MSB 15
`define PSIC_INT_EN_LSB 8
`define PSIC_INT_EN_RST 8'h00
`define PSIC_INT_STAT_RST 8'h00

// Cable diagnostic fields
`define PSIC_CABLE_START 15
`define PSIC_CABLE_RES_MSB 14
`define PSIC_CABLE_RES_LSB 13
`define PSIC_CABLE_SHORT 12
`define PSIC_CABLE_RSV_MSB 11
`define PSIC_CABLE_RSV_LSB 9
`define PSIC_CABLE_DIST_MSB 8
`define PSIC_CABLE_RSV_RST 3'h0

// PHY status / control one fields
`define PSIC_PS_PAUSE 9
`define PSIC_PS_LINK 8
`define PSIC_PS_POLARITY 7
`define PSIC_PS_MDIX 5
`define PSIC_PS_ENERGY 4
`define PSIC_PS_ISOLATE 3
`define PSIC_PS_MODE_MSB 2

// PHY control two fields
`define PSIC_CTRL2_XOVER 15
`define PSIC_CTRL2_INTLVL 9
`define PSIC_CTRL2_RST 16'h8100

// Management frame layout
`define PSIC_PREAMBLE_BITS 32
`define PSIC_HDR_BITS 13
`define PSIC_DATA_BITS 16
`define PSIC_OP_READ 2'h2
`define PSIC_OP_WRITE 2'h1

`endif

/* File: logic/psic_pkg.sv */
`default_nettype none
package psic_pkg;

  // Management frame states
  typedef enum logic [3:0] {
    ST_PRE = 4'h1,
    ST_HDR = 4'h2,
    ST_TA = 4'h4,
    ST_DATA = 4'h8
  } psic_state_t;

  // Event pulses, in the order of status bits 7 down to 0
  typedef struct packed {
    logic jabber;
    logic rx_err;
    logic page_rx;
    logic pd_fault;
    logic lp_ack;
    logic link_down;
    logic remote_fault;
    logic link_up;
  } psic_evt_t;

  // Live line condition from the PHY core
  typedef struct packed {
    logic pause_cap;
    logic link_up;
    logic polarity_rev;
    logic mdix_state;
    logic energy;
    logic [2:0] op_mode;
  } psic_line_t;

  // Cable test result
  typedef struct packed {
    logic [1:0] result;
    logic short_cable;
    logic [8:0] distance;
  } psic_cable_t;

endpackage
`default_nettype wire

/* File: logic/psic_regs.sv */
`default_nettype none
`include "psic_map.svh"

// Overview of operation
// - Interrupt bits 15..8 enable the eight event sources and reset to zero.
// - A one written to cable bit 15 starts a test, cleared when it ends.
// - Result 00 normal, 01 open, 10 short, 11 failed; bits 8..0 distance.
// - Cable bit 12 flags a cable under 10 meters and resets to zero.
// - PHY status bit 9 shows pause capability and resets to zero.
// - PHY status bit 7 shows reversed receive polarity.
// - PHY status bit 4 shows energy on the receive pair, reset zero.
// - PHY status bit 3 is writable and isolates the PHY, reset zero.
// - PHY status bits 2..0 code the mode as 000, 001, 010, 101 or 110.
// - Control two bit 15 selects the crossover algorithm, reset one.
// - Interrupt bit 15 enables the jabber source and resets to zero.
// - Control two bit 9 makes the interrupt pin active high, else low.
module psic_regs #(
  parameter logic [4:0] PHY_ADDR = 5'h00,
  parameter int PREAMBLE_BITS = `PSIC_PREAMBLE_BITS
) (
  input wire logic clk_sys, // System clock, 200 MHz
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic mdc, // Management clock pin
  input wire logic mdio_in, // Management data pin, input side
  output logic mdio_out, // Management data pin, output side
  output logic mdio_oe, // Management data pin drive enable
  input wire psic_pkg::psic_evt_t evt, // Event pulses from the PHY core
  input wire psic_pkg::psic_line_t line, // Live line condition
  input wire logic cable_done, // Cable test finished, one pulse
  input wire psic_pkg::psic_cable_t cable_res, // Result with cable_done
  output logic cable_start, // Cable test start, one pulse
  output logic isolate, // PHY isolate mode
  output logic crossover_algorithm_select, // Crossover algorithm
  output logic [15:0] phy_control_two, // Whole control two register
  output logic int_pin // Interrupt pin, programmable level
);

  // Refuse preamble lengths the six-bit counter cannot hold
  if (PREAMBLE_BITS < 1 || PREAMBLE_BITS > 63) begin : g_bad_preamble
    $error("PREAMBLE_BITS out of range");
  end

  localparam logic [5:0] PRE_MIN = 6'(PREAMBLE_BITS);
  localparam logic [5:0] HDR_LAST = 6'(`PSIC_HDR_BITS - 1);
  localparam logic [5:0] DATA_LAST = 6'(`PSIC_DATA_BITS - 1);

  logic mdc_s;
  logic mdio_s;
  logic mdc_d;
  logic next_mdc_d;
  logic rise;

  psic_pkg::psic_state_t state;
  psic_pkg::psic_state_t next_state;
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic [15:0] shreg;
  logic [15:0] next_shreg;
  logic [15:0] rd_sh;
  logic [15:0] next_rd_sh;
  logic op_read;
  logic next_op_read;
  logic [4:0] reg_addr;
  logic [4:0] next_reg_addr;
  logic next_mdio_out;
  logic next_mdio_oe;

  logic [7:0] int_en;
  logic [7:0] next_int_en;
  logic [7:0] int_stat;
  logic [7:0] next_int_stat;
  logic cable_busy;
  logic next_cable_busy;
  logic [2:0] cable_rsv;
  logic [2:0] next_cable_rsv;
  psic_pkg::psic_cable_t cable_q;
  psic_pkg::psic_cable_t next_cable_q;
  psic_pkg::psic_line_t line_q;
  logic next_isolate;
  logic [15:0] next_ctrl2;
  logic next_cable_start;
  logic next_int_pin;
  logic int_any;

  logic [15:0] rd_word;
  logic [7:0] rd_clear;
  logic wr_fire;
  logic [15:0] wr_data;

  // Management pins enter the system clock domain
  psic_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .d({mdc, mdio_in}),
    .q({mdc_s, mdio_s})
  );

  assign next_mdc_d = mdc_s;
  assign rise = mdc_s & ~mdc_d;
  assign crossover_algorithm_select = phy_control_two[`PSIC_CTRL2_XOVER];

  // Register image seen by a read; unmapped registers read zero
  always_comb begin
    rd_word = 16'h0000;
    case (reg_addr)
      `PSIC_REG_INT: begin
        rd_word = {int_en, int_stat};
      end
      `PSIC_REG_CABLE: begin
        rd_word = {cable_busy, cable_q.result, cable_q.short_cable,
                   cable_rsv, cable_q.distance};
      end
      `PSIC_REG_PHYSTAT: begin
        rd_word[`PSIC_PS_PAUSE] = line_q.pause_cap;
        rd_word[`PSIC_PS_LINK] = line_q.link_up;
        rd_word[`PSIC_PS_POLARITY] = line_q.polarity_rev;
        rd_word[`PSIC_PS_MDIX] = line_q.mdix_state;
        rd_word[`PSIC_PS_ENERGY] = line_q.energy;
        rd_word[`PSIC_PS_ISOLATE] = isolate;
        rd_word[`PSIC_PS_MODE_MSB:0] = line_q.op_mode;
      end
      `PSIC_REG_CTRL2: begin
        rd_word = phy_control_two;
      end
      default: begin
        rd_word = 16'h0000;
      end
    endcase
  end

  // Management frame receiver and read data driver
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_rd_sh = rd_sh;
    next_op_read = op_read;
    next_reg_addr = reg_addr;
    next_mdio_out = mdio_out;
    next_mdio_oe = mdio_oe;
    rd_clear = 8'h00;
    wr_fire = 1'b0;
    wr_data = {shreg[14:0], mdio_s};
    if (rise) begin
      case (state)
        psic_pkg::ST_PRE: begin
          if (mdio_s) begin
            next_cnt = (cnt == 6'h3F) ? cnt : cnt + 6'h01;
          end else begin
            next_state = (cnt >= PRE_MIN) ? psic_pkg::ST_HDR
                                          : psic_pkg::ST_PRE;
            next_cnt = 6'h00;
          end
        end
        psic_pkg::ST_HDR: begin
          next_shreg = {shreg[14:0], mdio_s};
          next_cnt = cnt + 6'h01;
          if (cnt == HDR_LAST) begin
            next_cnt = 6'h00;
            next_op_read = (next_shreg[11:10] == `PSIC_OP_READ);
            next_reg_addr = next_shreg[4:0];
            if (next_shreg[12] && next_shreg[9:5] == PHY_ADDR &&
                (next_shreg[11:10] == `PSIC_OP_READ ||
                 next_shreg[11:10] == `PSIC_OP_WRITE)) begin
              next_state = psic_pkg::ST_TA;
            end else begin
              next_state = psic_pkg::ST_PRE;
            end
          end
        end
        psic_pkg::ST_TA: begin
          if (cnt == 6'h00) begin
            next_cnt = 6'h01;
            if (op_read) begin
              next_mdio_oe = 1'b1;
              next_mdio_out = 1'b0;
              next_rd_sh = rd_word;
              if (reg_addr == `PSIC_REG_INT) begin
                rd_clear = int_stat;
              end
            end
          end else begin
            next_cnt = 6'h00;
            next_state = psic_pkg::ST_DATA;
            if (op_read) begin
              next_mdio_out = rd_sh[15];
              next_rd_sh = {rd_sh[14:0], 1'b0};
            end
          end
        end
        psic_pkg::ST_DATA: begin
          next_cnt = cnt + 6'h01;
          if (op_read) begin
            next_mdio_out = rd_sh[15];
            next_rd_sh = {rd_sh[14:0], 1'b0};
          end else begin
            next_shreg = wr_data;
          end
          if (cnt == DATA_LAST) begin
            next_cnt = 6'h00;
            next_state = psic_pkg::ST_PRE;
            next_mdio_oe = 1'b0;
            next_mdio_out = 1'b0;
            wr_fire = ~op_read;
          end
        end
        default: begin
          next_state = psic_pkg::ST_PRE;
          next_cnt = 6'h00;
          next_mdio_oe = 1'b0;
        end
      endcase
    end
  end

  // Register updates from writes, events and the cable engine
  always_comb begin
    next_int_en = int_en;
    next_cable_busy = cable_busy;
    next_cable_rsv = cable_rsv;
    next_cable_q = cable_q;
    next_isolate = isolate;
    next_ctrl2 = phy_control_two;
    next_cable_start = 1'b0;
    // Set beats the read clear so no event is dropped
    next_int_stat = (int_stat & ~rd_clear) | evt;
    if (cable_done) begin
      next_cable_busy = 1'b0;
      next_cable_q = cable_res;
    end
    if (wr_fire) begin
      case (reg_addr)
        `PSIC_REG_INT: begin
          // Only the enables take write data
          next_int_en = wr_data[`PSIC_INT_EN_MSB:`PSIC_INT_EN_LSB];
        end
        `PSIC_REG_CABLE: begin
          next_cable_rsv = wr_data[`PSIC_CABLE_RSV_MSB:`PSIC_CABLE_RSV_LSB];
          if (wr_data[`PSIC_CABLE_START] && !next_cable_busy) begin
            next_cable_busy = 1'b1;
            next_cable_start = 1'b1;
          end
        end
        `PSIC_REG_PHYSTAT: begin
          next_isolate = wr_data[`PSIC_PS_ISOLATE];
        end
        `PSIC_REG_CTRL2: begin
          next_ctrl2 = wr_data;
        end
        default: begin
          next_ctrl2 = phy_control_two;
        end
      endcase
    end
    int_any = |(int_stat & int_en);
    next_int_pin = phy_control_two[`PSIC_CTRL2_INTLVL] ? int_any
                                                      : ~int_any;
  end

  // State registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mdc_d <= 1'b0;
      state <= psic_pkg::ST_PRE;
      cnt <= 6'h00;
      shreg <= 16'h0000;
      rd_sh <= 16'h0000;
      op_read <= 1'b0;
      reg_addr <= 5'h00;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
      int_en <= `PSIC_INT_EN_RST;
      int_stat <= `PSIC_INT_STAT_RST;
      cable_busy <= 1'b0;
      cable_rsv <= `PSIC_CABLE_RSV_RST;
      cable_q <= '0;
      line_q <= '0;
      isolate <= 1'b0;
      phy_control_two <= `PSIC_CTRL2_RST;
      cable_start <= 1'b0;
      int_pin <= 1'b1;
    end else begin
      mdc_d <= next_mdc_d;
      state <= next_state;
      cnt <= next_cnt;
      shreg <= next_shreg;
      rd_sh <= next_rd_sh;
      op_read <= next_op_read;
      reg_addr <= next_reg_addr;
      mdio_out <= next_mdio_out;
      mdio_oe <= next_mdio_oe;
      int_en <= next_int_en;
      int_stat <= next_int_stat;
      cable_busy <= next_cable_busy;
      cable_rsv <= next_cable_rsv;
      cable_q <= next_cable_q;
      line_q <= line;
      isolate <= next_isolate;
      phy_control_two <= next_ctrl2;
      cable_start <= next_cable_start;
      int_pin <= next_int_pin;
    end
  end

endmodule
`default_nettype wire

/* File: logic/psic_sync.sv */
`default_nettype none
module psic_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic [WIDTH-1:0] d, // Asynchronous inputs
  output logic [WIDTH-1:0] q // Synchronised outputs
);

  logic [WIDTH-1:0] meta;

  // Two-flop synchroniser; the first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule
`default_nettype wire

/* File: tb/psic_host.sv */
`default_nettype none
`include "psic_map.svh"
module psic_host #(
  parameter int PRE = 32
) (
  output logic mdc, // Management clock
  output logic mdio_in, // Resolved data line
  input wire logic mdio_out, // Device data
  input wire logic mdio_oe // Device drive enable
);
  timeunit 1ns;
  timeprecision 100ps;
  logic h_oe = 1'b0;
  logic h_d = 1'b1;
  initial mdc = 1'b0;
  // Pulled-up line: released means one
  assign mdio_in = mdio_oe ? mdio_out : (h_oe ? h_d : 1'b1);
  // One frame; clock stands low between frames
  task automatic xfer(input logic rd_op, input logic [4:0] ra,
      input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] f;
    f = {2'b01, rd_op ? `PSIC_OP_READ : `PSIC_OP_WRITE, 5'h00, ra,
      2'b10, wd};
    rd = 16'h0000;
    for (int i = PRE + 31; i >= 0; i--) begin
      h_oe = !(rd_op && i < 18);
      h_d = (i > 31) || f[i[4:0]];
      #62.5;
      if (rd_op && i < 16) rd[i[3:0]] = mdio_in;
      mdc = 1'b1;
      #62.5;
      mdc = 1'b0;
    end
    h_oe = 1'b0;
    // Short idle gap so no frame starts in the step that ends one
    #5;
  endtask
endmodule
`default_nettype wire

/* File: tb/psic_regs_chk.sv */
`default_nettype none
module psic_chk (
  input wire logic clk_sys, // Clock
  input wire logic sys_rst, // Reset
  input wire logic mdio_oe, // Device drives data
  input wire psic_pkg::psic_evt_t evt, // Event pulses
  input wire logic cable_done, // Test finished
  input wire logic cable_start, // Test start
  input wire logic isolate, // Isolate level
  input wire logic crossover_algorithm_select, // Algorithm
  input wire logic [15:0] phy_control_two, // Control two
  input wire logic int_pin // Interrupt pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic busy;
  logic next_busy;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Track a cable test in flight
  always_comb begin
    next_busy = busy;
    if (cable_start) next_busy = 1'b1;
    if (cable_done || sys_rst) next_busy = 1'b0;
  end
  always_ff @(posedge clk_sys) begin
    busy <= next_busy;
  end
  a_reset_outputs:
    assert property ($fell(sys_rst) |-> int_pin && !isolate
      && !mdio_oe && phy_control_two == 16'h8100) else $error("reset");
  a_xover_mirror:
    assert property (crossover_algorithm_select == phy_control_two[15])
    else $error("algorithm select");
  a_start_pulse:
    assert property (cable_start |=> !cable_start) else $error("pulse");
  a_no_restart:
    assert property (cable_start |-> !busy) else $error("restart");
  a_start_on_write:
    assert property (cable_start |-> !mdio_oe && !$past(mdio_oe))
    else $error("start in read");
  a_isolate_write:
    assert property ($changed(isolate) |-> !mdio_oe) else $error("iso");
  a_pin_level:
    assert property ($changed(phy_control_two[9]) && evt == 8'h00
      && $past(evt) == 8'h00 && !$past(sys_rst) |=> $changed(int_pin))
    else $error("pin level");
  a_ctrl_read:
    assert property (mdio_oe |-> $stable(phy_control_two))
    else $error("read changed control");
endmodule
bind psic_regs psic_chk i_chk (.clk_sys, .sys_rst, .mdio_oe, .evt,
  .cable_done, .cable_start, .isolate, .crossover_algorithm_select,
  .phy_control_two, .int_pin);
`default_nettype wire

/* File: tb/tb_psic_regs.sv */
`default_nettype none
`include "psic_map.svh"
module tb_psic_regs;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic mdc, mdio_in, mdio_out, mdio_oe, cable_start;
  logic isolate, crossover_algorithm_select, int_pin;
  logic cable_done = 1'b0;
  logic [15:0] phy_control_two, rv;
  psic_pkg::psic_evt_t evt = 8'h00;
  psic_pkg::psic_line_t line = 8'h00;
  psic_pkg::psic_cable_t cable_res = 12'h000;
  int err_count = 0;
  int checks_done = 0;
  int starts = 0;
  always #2.5 clk_sys = ~clk_sys;
  // Count test start pulses
  always @(posedge clk_sys) if (cable_start === 1'b1) starts++;
  psic_regs #(.PREAMBLE_BITS(8)) i_dut (.clk_sys, .sys_rst, .mdc,
    .mdio_in, .mdio_out, .mdio_oe, .evt, .line, .cable_done,
    .cable_res, .cable_start, .isolate, .crossover_algorithm_select,
    .phy_control_two, .int_pin);
  psic_host #(.PRE(8)) i_host (.mdc, .mdio_in, .mdio_out, .mdio_oe);
  // Compare and tally
  task automatic chk(input string nm, input logic [15:0] s, e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    i_host.xfer(1'b0, ra, d, rv);
  endtask
  task automatic rdc(input logic [4:0] ra, input logic [15:0] e);
    i_host.xfer(1'b1, ra, 16'h0000, rv);
    chk("register", rv, e);
  endtask
  task automatic pulse(input logic [7:0] e);
    evt = e;
    cyc(1);
    evt = 8'h00;
    cyc(3);
  endtask
  task automatic conclude();
    $display("checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Reset values at pins and in registers
  task automatic t_reset();
    chk("int_pin", int_pin, 1'b1);
    chk("xover", crossover_algorithm_select, 1'b1);
    chk("control two", phy_control_two, `PSIC_CTRL2_RST);
    chk("isolate", isolate, 1'b0);
    rdc(`PSIC_REG_INT, 16'h0000);
    rdc(`PSIC_REG_CTRL2, `PSIC_CTRL2_RST);
    rdc(`PSIC_REG_CABLE, 16'h0000);
    rdc(`PSIC_REG_PHYSTAT, 16'h0000);
  endtask
  // Each source alone gates the pin, then polarity and crossover
  task automatic t_intr();
    logic [15:0] en;
    for (int i = 0; i < 8; i++) begin
      en = 16'h0100 << i;
      wr(`PSIC_REG_INT, en | 16'h00FF);
      rdc(`PSIC_REG_INT, en);
      pulse(~en[15:8]);
      chk("masked", int_pin, 1'b1);
      pulse(en[15:8]);
      chk("raised", int_pin, 1'b0);
      rdc(`PSIC_REG_INT, en | 16'h00FF);
      chk("cleared", int_pin, 1'b1);
    end
    wr(`PSIC_REG_CTRL2, 16'h8300);
    chk("control two", phy_control_two, 16'h8300);
    chk("high idle", int_pin, 1'b0);
    pulse(8'h80);
    chk("high set", int_pin, 1'b1);
    wr(`PSIC_REG_CTRL2, 16'h0000);
    chk("xover", crossover_algorithm_select, 1'b0);
    rdc(`PSIC_REG_CTRL2, 16'h0000);
    chk("low set", int_pin, 1'b0);
  endtask
  // Event held up to the very edge at which a read clears its flag;
  // the first turnaround rise lands 562 cycles in and the clearing edge is 565
  task automatic t_race();
    logic [15:0] got;
    rdc(`PSIC_REG_INT, 16'h8080);
    cyc(1);
    fork
      i_host.xfer(1'b1, `PSIC_REG_INT, 16'h0000, got);
      begin
        cyc(560);
        evt = 8'h80;
        cyc(5);
        evt = 8'h00;
      end
    join
    chk("race read", got, 16'h8080);
    chk("pin kept", int_pin, 1'b0);
    rdc(`PSIC_REG_INT, 16'h8080);
    chk("pin clear", int_pin, 1'b1);
    rdc(`PSIC_REG_INT, 16'h8000);
  endtask
  // Live status fields across all defined modes
  task automatic t_status();
    logic [14:0] m;
    logic [4:0] b;
    logic [15:0] ev;
    m = {3'h6, 3'h5, 3'h2, 3'h1, 3'h0};
    wr(`PSIC_REG_PHYSTAT, 16'hFFFF);
    chk("isolate", isolate, 1'b1);
    for (int k = 0; k < 5; k++) begin
      b = k[0] ? 5'h15 : 5'h0A;
      line = {b, m[3*k +: 3]};
      ev = {6'h00, b[4:2], 1'b0, b[1:0], 1'b1, m[3*k +: 3]};
      rdc(`PSIC_REG_PHYSTAT, ev);
    end
    wr(`PSIC_REG_PHYSTAT, 16'h0000);
    chk("isolate", isolate, 1'b0);
  endtask
  // Cable test per result code, with a refused restart
  task automatic t_cable();
    logic [15:0] pv;
    logic [15:0] cv;
    pv = 16'h0000;
    for (int k = 0; k < 4; k++) begin
      cv = {1'b0, k[1:0], k[0], 3'h0, 9'h1A5 ^ k[8:0]};
      wr(`PSIC_REG_CABLE, 16'h8E00);
      wr(`PSIC_REG_CABLE, 16'h8E00);
      chk("starts", 16'(starts), 16'(k + 1));
      rdc(`PSIC_REG_CABLE, 16'h8E00 | pv);
      cable_res = {cv[14:12], cv[8:0]};
      cable_done = 1'b1;
      cyc(1);
      cable_done = 1'b0;
      cable_res = 12'hFFF;
      rdc(`PSIC_REG_CABLE, 16'h0E00 | cv);
      pv = cv;
    end
    wr(5'h1C, 16'hFFFF);
    rdc(5'h1C, 16'h0000);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    cyc(3);
    t_reset();
    t_intr();
    t_race();
    t_status();
    t_cable();
    conclude();
  end
  // Cut a hang short
  initial begin
    #450us;
    err_count++;
    conclude();
  end
endmodule
`default_nettype wire
